// ===== design/nv_host_pkg.sv
// Constants and carrier types for the nonvolatile SRAM pin controller.
// Assumes a single 250 MHz clock; all pin timing is counted in its cycles.
package nv_host_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_PS = 4000;
   localparam int READ_ACCESS_NS = 35;
   localparam int WRITE_PULSE_NS = 30;
   localparam int NV_INIT_NS = 25;
   localparam int PIN_SETUP_NS = 5;
   localparam int STORE_TIME_MS = 10;
   localparam int RECALL_TIME_US = 20;
   localparam int POWERUP_RECALL_US = 650;

   // Least times round up to whole cycles
   localparam int READ_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
   localparam int WRITE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
   localparam int INIT_CYC = (NV_INIT_NS * 1000 + CLK_PERIOD_PS - 1)
                             / CLK_PERIOD_PS;
   localparam int SETUP_CYC = (PIN_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
   // Waits on the device are maxima, so the host must wait at least them
   localparam int STORE_CYC = (STORE_TIME_MS * 1000000) / (CLK_PERIOD_PS
                              / 1000);
   localparam int RECALL_CYC = (RECALL_TIME_US * 1000) / (CLK_PERIOD_PS
                               / 1000);
   localparam int POWERUP_CYC = (POWERUP_RECALL_US * 1000)
                                / (CLK_PERIOD_PS / 1000);

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_STORE, OP_RECALL} op_t;

   // Control pins, all active low
   typedef struct packed {
      logic chipEnN;
      logic writeEnN;
      logic outEnN;
      logic nonvolatileSelectN;
   } pin_ctl_t;

   localparam pin_ctl_t PINS_IDLE = 4'hf;

endpackage : nv_host_pkg

// ===== design/nv_sram_pin_control.sv
// Host-side controller that drives a 2K x 8 nonvolatile SRAM by its pins.
// Assumes the memory pins are sampled synchronously and that the memory
// powers up together with this block's reset release.
`timescale 1ns/100ps

module nv_sram_pin_control
   import nv_host_pkg::*;
#(
   parameter int ADDR_W = 11,
   parameter int DATA_W = 8,
   parameter int STORE_CYCLES = STORE_CYC,
   parameter int RECALL_CYCLES = RECALL_CYC,
   parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Command port
   input wire logic cmdValid,
   output logic cmdReady,
   input wire op_t cmdOp,
   input wire logic [ADDR_W-1:0] cmdAddr,
   input wire logic [DATA_W-1:0] cmdWrData,
   // Completion
   output logic doneValid,
   output logic [DATA_W-1:0] doneRdData,
   output logic nvBusy,
   // Memory pins
   output pin_ctl_t memPins,
   output logic [ADDR_W-1:0] memAddr,
   input wire logic [DATA_W-1:0] memDataIn,
   output logic [DATA_W-1:0] memDataOut,
   output logic memDataOe
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [2:0] {S_POWERUP, S_IDLE, S_SETUP, S_PULSE, S_HOLD,
                             S_BUSY} phase_t;

   typedef struct packed {
      phase_t phase;
      op_t op;
      logic [31:0] count;
      pin_ctl_t pins;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
      logic dataOe;
      logic [DATA_W-1:0] rdData;
      logic done;
   } ctl_state_t;

   ctl_state_t st;
   ctl_state_t next_st;

   // Length of the active phase for each operation
   function automatic logic [31:0] pulse_len(input op_t op);
      case (op)
         OP_READ: pulse_len = 32'(READ_CYC);
         OP_WRITE: pulse_len = 32'(WRITE_CYC);
         default: pulse_len = 32'(INIT_CYC);
      endcase
   endfunction : pulse_len

   // ****************************************************************
   // Next state
   // ****************************************************************
   // Sequencer; every cycle count but the setup count is loaded minus one and run to zero
   always_comb
   begin
      next_st = st;
      next_st.done = 1'b0;
      case (st.phase)
         S_POWERUP:
         begin
            // Device recalls by itself; just keep off the pins meanwhile
            if (st.count == 32'h0)
               next_st.phase = S_IDLE;
            else
               next_st.count = st.count - 32'h1;
         end
         S_IDLE:
         begin
            next_st.pins = PINS_IDLE;
            if (cmdValid)
            begin
               // Address moves only while every control is high
               next_st.addr = cmdAddr;
               next_st.wrData = cmdWrData;
               next_st.op = cmdOp;
               next_st.phase = S_SETUP;
               next_st.count = 32'(SETUP_CYC);
            end
         end
         S_SETUP:
         begin
            // Chip enable and select first, with WE and OE still high;
            // this gives the 5 ns setup before the initiating edge
            next_st.pins.chipEnN = 1'b0;
            next_st.pins.nonvolatileSelectN = (st.op == OP_READ ||
                                               st.op == OP_WRITE);
            if (st.count == 32'h0)
            begin
               next_st.phase = S_PULSE;
               next_st.count = pulse_len(st.op) - 32'h1;
               case (st.op)
                  OP_READ: next_st.pins.outEnN = 1'b0;
                  OP_WRITE:
                  begin
                     next_st.pins.writeEnN = 1'b0;
                     next_st.dataOe = 1'b1;
                  end
                  OP_STORE: next_st.pins.writeEnN = 1'b0;
                  OP_RECALL: next_st.pins.outEnN = 1'b0;
                  default: next_st.pins = PINS_IDLE;
               endcase
            end
            else
               next_st.count = st.count - 32'h1;
         end
         S_PULSE:
         begin
            // Hold the pattern for the full pulse, then lift everything
            if (st.count == 32'h0)
            begin
               next_st.pins = PINS_IDLE;
               next_st.phase = S_HOLD;
               if (st.op == OP_READ)
                  next_st.rdData = memDataIn;
            end
            else
               next_st.count = st.count - 32'h1;
         end
         S_HOLD:
         begin
            // Data held one cycle past WE rise for write hold time
            next_st.dataOe = 1'b0;
            if (st.op == OP_STORE)
            begin
               next_st.phase = S_BUSY;
               next_st.count = 32'(STORE_CYCLES) - 32'h1;
            end
            else if (st.op == OP_RECALL)
            begin
               next_st.phase = S_BUSY;
               next_st.count = 32'(RECALL_CYCLES) - 32'h1;
            end
            else
            begin
               next_st.phase = S_IDLE;
               next_st.done = 1'b1;
            end
         end
         S_BUSY:
         begin
            // No access while the device runs its own cycle
            if (st.count == 32'h0)
            begin
               next_st.phase = S_IDLE;
               next_st.done = 1'b1;
            end
            else
               next_st.count = st.count - 32'h1;
         end
         default: next_st.phase = S_IDLE;
      endcase
   end

   // State register; clock enable low freezes everything
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '0;
         st.phase <= S_POWERUP;
         st.count <= 32'(POWERUP_CYCLES) - 32'h1;
         st.pins <= PINS_IDLE;
      end
      else if (ce)
         st <= next_st;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Ready is combinational; a command is taken on the next edge
   assign cmdReady = (st.phase == S_IDLE);
   assign doneValid = st.done;
   assign doneRdData = st.rdData;
   assign nvBusy = (st.phase == S_BUSY) || (st.phase == S_POWERUP);
   assign memPins = st.pins;
   assign memAddr = st.addr;
   assign memDataOut = st.wrData;
   assign memDataOe = st.dataOe;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk iff ce);
   endclocking
   default disable iff (!rst_b);

   // Enabled cycles since reset, saturating, for the power-up wait
   logic [31:0] upCount;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         upCount <= 32'h0;
      else if (ce && upCount != 32'hffffffff)
         upCount <= upCount + 32'h1;
   end

   property p_addr_quiet;
      !$stable(memAddr) |-> memPins.chipEnN && memPins.nonvolatileSelectN;
   endproperty
   a_addr_quiet: assert property (p_addr_quiet)
      else $error("address moved while selected");

   property p_store_hold;
      $fell(memPins.writeEnN) && !memPins.nonvolatileSelectN |->
         (!memPins.writeEnN && !memPins.chipEnN)[*7];
   endproperty
   a_store_hold: assert property (p_store_hold)
      else $error("store pattern shorter than 25 ns");

   property p_store_pattern;
      !memPins.writeEnN && !memPins.nonvolatileSelectN |->
         !memPins.chipEnN && memPins.outEnN;
   endproperty
   a_store_pattern: assert property (p_store_pattern)
      else $error("store pattern wrong");

   property p_recall_hold;
      $fell(memPins.outEnN) && !memPins.nonvolatileSelectN |->
         (!memPins.outEnN && memPins.writeEnN && !memPins.chipEnN)[*7];
   endproperty
   a_recall_hold: assert property (p_recall_hold)
      else $error("recall pattern broken");

   property p_no_noop;
      !(!memPins.chipEnN && !memPins.nonvolatileSelectN &&
        !memPins.writeEnN && !memPins.outEnN);
   endproperty
   a_no_noop: assert property (p_no_noop)
      else $error("no-operation pattern driven");

   property p_write_drive;
      memDataOe |-> memPins.nonvolatileSelectN && memPins.outEnN &&
         (!memPins.writeEnN || $past(!memPins.writeEnN));
   endproperty
   a_write_drive: assert property (p_write_drive)
      else $error("data driven outside write");

   property p_read_capture;
      doneValid && st.op == OP_READ |->
         $past(!memPins.outEnN && memPins.writeEnN, 2) && !memDataOe;
   endproperty
   a_read_capture: assert property (p_read_capture)
      else $error("read finished without read pattern");

   property p_powerup_wait;
      cmdReady |-> upCount >= 32'(POWERUP_CYCLES);
   endproperty
   a_powerup_wait: assert property (p_powerup_wait)
      else $error("ready before power-up recall time");

   property p_busy_quiet;
      nvBusy |-> memPins == PINS_IDLE && !cmdReady;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("pins active while device busy");

   c_read: cover property (doneValid && st.op == OP_READ);
   c_write: cover property (doneValid && st.op == OP_WRITE);
   c_store: cover property (doneValid && st.op == OP_STORE);
   c_recall: cover property (doneValid && st.op == OP_RECALL);

endmodule : nv_sram_pin_control

// ===== tb/nv_sram_model.sv
// Behavioural 2K x 8 nonvolatile SRAM that stands on the memory pins.
// Assumes pins are sampled on the host clock; rst_b stands for power.
`timescale 1ns/100ps
module nv_sram_model
   import nv_host_pkg::*;
#(
   parameter int BUSY_CYC = 8
)
(
   // Clock and power
   input wire logic clk,
   input wire logic rst_b,
   // Memory pins
   input wire pin_ctl_t pins,
   input wire logic [10:0] addr,
   input wire logic [7:0] wrData,
   output logic [7:0] rdData,
   output logic fault
);
   logic [7:0] sram [2048];
   logic [7:0] rom [2048];
   int busy;
   int held;
   logic quiet;
   logic ceWas;
   logic [10:0] lastAddr;
   logic st;
   logic rc;
   initial foreach (rom[i]) rom[i] = 8'h00;
   // Whole-array copies happen at once; busy only models the dead time
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sram = rom;
         busy = BUSY_CYC;
         held = 0;
         quiet = 1'b0;
         ceWas = 1'b1;
         lastAddr = addr;
         rdData <= 8'h00;
         fault <= 1'b0;
      end
      else
      begin
         st = !pins.chipEnN && !pins.writeEnN && pins.outEnN
              && !pins.nonvolatileSelectN;
         rc = !pins.chipEnN && pins.writeEnN && !pins.outEnN
              && !pins.nonvolatileSelectN;
         if (pins.chipEnN)
            quiet = 1'b0;
         else if (ceWas && !pins.writeEnN)
            quiet = 1'b1;
         ceWas = pins.chipEnN;
         if (busy > 0)
            busy--;
         else if (st)
         begin
            rom = sram;
            busy = BUSY_CYC;
         end
         else if (rc)
         begin
            sram = rom;
            busy = BUSY_CYC;
         end
         else if (!pins.chipEnN && !pins.writeEnN && pins.nonvolatileSelectN)
            sram[addr] = wrData; // no-op patterns fall through
         // Released bus shows the inverse of its last value each cycle
         rdData <= (!pins.chipEnN && !pins.outEnN && pins.writeEnN
                    && pins.nonvolatileSelectN && !quiet && busy == 0)
                   ? sram[addr] : ~rdData;
         if (!st && held > 0 && held < INIT_CYC)
            fault <= 1'b1;
         held = st ? held + 1 : 0;
         if (addr != lastAddr && !((pins.chipEnN || pins.writeEnN)
             && pins.nonvolatileSelectN))
            fault <= 1'b1;
         lastAddr = addr;
      end
   end
endmodule : nv_sram_model

// ===== tb/nv_sram_pin_control_tb_top.sv
// Self-checking bench: controller against the memory model.
// Assumes short store, recall and power-up counts for a quick run.
`timescale 1ns/100ps
module nv_sram_pin_control_tb_top
   import nv_host_pkg::*;
;
   localparam int ST = 20;
   localparam int PU = 10;
   // Enabled-edge freeze applied during every power-up wait
   localparam int FRZ = 5;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic cmdValid = 1'b0;
   op_t cmdOp = OP_READ;
   logic [10:0] cmdAddr = 11'h000;
   logic [7:0] cmdWrData = 8'h00;
   logic cmdReady, doneValid, nvBusy, memDataOe, fault;
   logic [7:0] doneRdData, memDataOut, memDataIn, bus;
   pin_ctl_t memPins;
   logic [10:0] memAddr;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   int seed = 32'h7eab1dab;
   logic [7:0] expS [2048];
   logic [7:0] expE [2048];
   logic [10:0] adr [$];
   // Data pins: host drives when enabled, else the memory
   assign bus = memDataOe ? memDataOut : memDataIn;
   always #2 clk = ~clk;
   nv_sram_pin_control #(.STORE_CYCLES(ST), .RECALL_CYCLES(20),
      .POWERUP_CYCLES(PU)) dut (.clk(clk), .rst_b(rst_b), .ce(ce),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
      .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .doneValid(doneValid),
      .doneRdData(doneRdData), .nvBusy(nvBusy), .memPins(memPins),
      .memAddr(memAddr), .memDataIn(bus), .memDataOut(memDataOut),
      .memDataOe(memDataOe));
   nv_sram_model mem (.clk(clk), .rst_b(rst_b), .pins(memPins),
      .addr(memAddr), .wrData(bus), .rdData(memDataIn), .fault(fault));
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done();
      $display("Compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   // Request held until the edge that takes it, then done awaited
   task automatic op(op_t o, logic [10:0] a, logic [7:0] d);
      @(negedge clk);
      cmdValid = 1'b1;
      cmdOp = o;
      cmdAddr = a;
      cmdWrData = d;
      // Ready is judged off the edge, so the taking edge is the next one
      while (cmdReady !== 1'b1)
         @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      cmdValid = 1'b0;
      n = 0;
      while (doneValid !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      chk("doneValid", 1, doneValid);
   endtask : op
   task automatic wr_all();
      logic [7:0] d;
      foreach (adr[i])
      begin
         d = 8'($random(seed));
         op(OP_WRITE, adr[i], d);
         expS[adr[i]] = d;
      end
   endtask : wr_all
   task automatic rd_all();
      foreach (adr[i])
      begin
         op(OP_READ, adr[i], 8'h00);
         chk("rdData", expS[adr[i]], doneRdData);
      end
   endtask : rd_all
   task automatic power_up();
      repeat (3) @(posedge clk);
      chk("busyInReset", 1, nvBusy);
      chk("idlePins", PINS_IDLE, memPins);
      @(negedge clk);
      rst_b = 1'b1;
      // Clock enable low must stretch the wait by exactly its length
      ce = 1'b0;
      repeat (FRZ) @(negedge clk);
      ce = 1'b1;
      n = FRZ;
      while (cmdReady !== 1'b1)
      begin
         @(negedge clk);
         n++;
      end
      chk("powerupWait", PU + FRZ, n);
      expS = expE;
   endtask : power_up
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fail_count++;
         test_done();
      end
   end
   initial
   begin
      foreach (expE[i]) expE[i] = 8'h00;
      adr = '{11'h000, 11'h7ff};
      repeat (10) adr.push_back(11'($random(seed)));
      power_up();
      wr_all();
      rd_all();
      op(OP_STORE, 11'h000, 8'h00);
      chk("storeWait", 1, n > ST);
      expE = expS;
      wr_all();
      rd_all();
      op(OP_RECALL, 11'h000, 8'h00);
      expS = expE;
      rd_all();
      wr_all();
      @(negedge clk);
      rst_b = 1'b0;
      power_up();
      rd_all();
      chk("pinFault", 0, fault);
      test_done();
   end
endmodule : nv_sram_pin_control_tb_top
